/* File: i2nv_regs.svh */
`ifndef I2NV_REGS_SVH
`define I2NV_REGS_SVH

// Register byte offsets, compared against haddr[11:0].
`define I2NV_CTRL_OFS       12'h000
`define I2NV_STAT_OFS       12'h004

// Control register fields and reset value.
`define I2NV_CTRL_EN_BIT    0
`define I2NV_CTRL_RST       1'b1

// Status register fields.
`define I2NV_STAT_BUSY_BIT  0
`define I2NV_STAT_RD_BIT    1
`define I2NV_STAT_WP_BIT    2
`define I2NV_STAT_ADDR_LSB  16

// Bit counter values: last data bit taken, acknowledge clock taken.
`define I2NV_CNT_ACK        4'd8
`define I2NV_CNT_POST       4'd9

`endif

/* File: i2nv_pkg.sv */
package i2nv_pkg;

    // Protocol position of the slave engine.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_WR,
        ST_RD
    } i2nv_state_e;

    // Bus condition seen in one system clock cycle.
    typedef enum logic [2:0] {
        COND_NONE,
        COND_START,
        COND_STOP,
        COND_DATA,
        COND_ACK
    } i2nv_cond_e;

    // Two-wire pins as seen by the block.
    typedef struct packed {
        logic scl;
        logic sda;
    } i2nv_pin_in_s;

    // Open-drain data pin: value and active-low output enable.
    typedef struct packed {
        logic sda;
        logic sda_oe_n;
    } i2nv_pin_out_s;

endpackage : i2nv_pkg

/* File: i2nv_array.sv */
`timescale 1ns/10ps

// Byte-wide storage with a single write port and a direct read port.
// The read port is combinational so a byte is ready on the same edge
// that the serial side needs it; no extra cycle of latency appears.
module i2nv_array #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 8
) (
    input  wire logic              clk_sys_i,
    input  wire logic              ce_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

    // The write completes in one system clock, far inside a bus bit.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && we_i) begin
            mem_ff[addr_i] <= wdata_i;
        end
    end

    // Read returns the byte at the current address.
    assign rdata_o = mem_ff[addr_i];

endmodule // i2nv_array

/* File: i2nv_top.sv */
// Operation
// R1: Answer only when straps equal the select bits of the slave address.
// R2: Unconnected straps read low through their pad pull-downs.
// R3: SDA is only pulled low or released, never driven high.
// R4: Sample SDA on rising SCL, change outgoing SDA after falling SCL.
// R5: Write-protect high blocks every array write.
// R6: Write-protect low makes all locations writable; open pin reads low.
// R7: Storage is 32768 locations of one byte each.
// R8: Two address bytes; top bit ignored, 15 bits pick the byte.
// R9: Each array write finishes inside the transfer; no busy period.
// R10: The block is a slave only and never drives SCL.
// R11: SDA rising while SCL high is detected as stop.
// R12: A stop aborts any operation and returns to idle.
// R13: Master must own SDA to issue a stop, not during reads.
// R14: SDA falling while SCL high is detected as start.
// R15: A start aborts any operation and readies a new command.
// R16: Master begins commands with start and ends them with stop.
// R17: After a supply dip the master issues a start first.
// R18: SDA is valid and stable while SCL is high, except conditions.
// R19: Bus logic tells apart start, stop, data bit and acknowledge.
// R20: Receiver pulls SDA low after bit eight; high means nack.
// R21: Address bits 3..1 match straps, bit 0 is direction, 7..4 type.
// R22: Address latch increments per byte and wraps top to zero.
// R23: Protected writes get no acknowledge and keep the address.
// R24: SCL and SDA pass two flip-flops before edge detection.
// R25: A start clears the bit counter; next byte is slave address.
`timescale 1ns/10ps
`include "i2nv_regs.svh"

module i2nv_top #(
    parameter int          ADDR_W   = 15,
    parameter logic [3:0]  DEV_TYPE = 4'h5 // Arbitrary device-type code.
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   resetn_i,
    input  wire logic                   ce_i,
    input  wire i2nv_pkg::i2nv_pin_in_s pins_i,
    output i2nv_pkg::i2nv_pin_out_s     pins_o,
    input  wire logic [2:0]             device_select_straps_i,
    input  wire logic                   wp_i,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic [31:0]                 hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o
);
    import i2nv_pkg::*;

    localparam int SYNC_W = 6;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h03; // SCL and SDA idle high.

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] pin_raw;
    logic [1:0]        prev_ff;
    logic              scl_q;
    logic              sda_q;
    logic              wp_q;
    logic [2:0]        straps_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    i2nv_cond_e        cond;
    i2nv_state_e       state_ff;
    logic [3:0]        bit_cnt_ff;
    logic [7:0]        rx_ff;
    logic [7:0]        tx_ff;
    logic [7:0]        ahi_ff;
    logic              ack_ok_ff;
    logic              oe_n_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic              byte_done;
    logic              dev_match;
    logic              mem_we;
    logic [7:0]        rdata;
    logic              en_ff;
    logic              ap_valid_ff;
    logic              ap_write_ff;
    logic [11:0]       ap_addr_ff;
    logic [31:0]       hrdata_ff;
    logic              ahb_take;

    // Pins are asynchronous to clk_sys_i; each passes two stages first.
    // The pad pull-downs make open straps and write-protect sample as 0.
    // SCL and SDA reset to their idle level so release shows no edge.
    assign pin_raw = {device_select_straps_i,         // [R2]
                      wp_i, pins_i.sda, pins_i.scl};  // [R6] [R24]
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync1_ff[gi] <= SYNC_IDLE[gi];
                    sync2_ff[gi] <= SYNC_IDLE[gi];
                end else if (ce_i) begin
                    sync1_ff[gi] <= pin_raw[gi];                 // [R24]
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    assign scl_q    = sync2_ff[0];
    assign sda_q    = sync2_ff[1];
    assign wp_q     = sync2_ff[2];
    assign straps_q = sync2_ff[5:3];

    // Previous synchronised levels, for edge detection only.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_ff <= 2'h3;
        end else if (ce_i) begin
            prev_ff <= {sda_q, scl_q};
        end
    end

    // Edges and the start and stop conditions; SCL is only ever an input.
    assign scl_rise  = scl_q && !prev_ff[0];                    // [R10]
    assign scl_fall  = !scl_q && prev_ff[0];
    assign start_det = scl_q && prev_ff[0] && prev_ff[1] && !sda_q; // [R14]
    assign stop_det  = scl_q && prev_ff[0] && !prev_ff[1] && sda_q; // [R11]

    // Classify the cycle; start and stop outrank clock edges.
    always_comb begin
        cond = COND_NONE;
        if (start_det) begin
            cond = COND_START;                                   // [R19]
        end else if (stop_det) begin
            cond = COND_STOP;
        end else if (scl_rise && bit_cnt_ff == `I2NV_CNT_ACK) begin
            cond = COND_ACK;
        end else if (scl_rise) begin
            cond = COND_DATA;
        end
    end

    // A byte ends at the falling SCL after its eighth bit.
    assign byte_done = scl_fall && (bit_cnt_ff == `I2NV_CNT_ACK);
    assign dev_match = (rx_ff[7:4] == DEV_TYPE) &&
                       (rx_ff[3:1] == straps_q);                 // [R1] [R21]
    assign mem_we    = en_ff && (state_ff == ST_WR) && byte_done &&
                       !wp_q;                                    // [R5] [R9]

    // Receive path: bits are taken only on rising SCL, MSB first.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_ff      <= 8'h00;
            bit_cnt_ff <= 4'h0;
            ack_ok_ff  <= 1'b0;
        end else if (ce_i) begin
            if (cond == COND_START || !en_ff) begin
                bit_cnt_ff <= 4'h0;                              // [R25]
            end else if (cond == COND_DATA) begin
                rx_ff      <= {rx_ff[6:0], sda_q};               // [R4] [R18]
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (cond == COND_ACK) begin
                bit_cnt_ff <= `I2NV_CNT_POST;
                ack_ok_ff  <= !sda_q;                            // [R20]
            end else if (scl_fall && bit_cnt_ff == `I2NV_CNT_POST) begin
                bit_cnt_ff <= 4'h0;
            end
        end
    end

    // Protocol engine and the open-drain data driver. The driver only
    // changes on falling SCL, so SDA never moves while SCL is high
    // except when released by a start, a stop or a cleared enable.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
            oe_n_ff  <= 1'b1;
            tx_ff    <= 8'h00;
            ahi_ff   <= 8'h00;
        end else if (ce_i) begin
            if (!en_ff) begin
                state_ff <= ST_IDLE;
                oe_n_ff  <= 1'b1;
            end else if (cond == COND_START) begin
                state_ff <= ST_DEV;                              // [R15] [R25]
                oe_n_ff  <= 1'b1;
            end else if (cond == COND_STOP) begin
                state_ff <= ST_IDLE;                             // [R12]
                oe_n_ff  <= 1'b1;
            end else if (state_ff != ST_IDLE && byte_done) begin
                unique case (state_ff)
                    ST_DEV: begin
                        if (dev_match) begin
                            oe_n_ff  <= 1'b0;                    // [R20]
                            state_ff <= rx_ff[0] ? ST_RD : ST_AHI; // [R21]
                        end else begin
                            state_ff <= ST_IDLE;                 // [R1]
                        end
                    end
                    ST_AHI: begin
                        ahi_ff   <= rx_ff;
                        oe_n_ff  <= 1'b0;
                        state_ff <= ST_ALO;
                    end
                    ST_ALO: begin
                        oe_n_ff  <= 1'b0;
                        state_ff <= ST_WR;
                    end
                    ST_WR: begin
                        oe_n_ff  <= wp_q;                        // [R23]
                    end
                    ST_RD: begin
                        oe_n_ff  <= 1'b1;                        // [R20]
                    end
                    ST_IDLE: begin
                        oe_n_ff  <= 1'b1;
                    end
                endcase
            end else if (state_ff != ST_IDLE && scl_fall &&
                         bit_cnt_ff == `I2NV_CNT_POST) begin
                if (state_ff == ST_RD && ack_ok_ff) begin
                    tx_ff   <= {rdata[6:0], 1'b0};
                    oe_n_ff <= rdata[7];                         // [R4] [R3]
                end else if (state_ff == ST_RD) begin
                    state_ff <= ST_IDLE;                         // [R20]
                    oe_n_ff  <= 1'b1;
                end else begin
                    oe_n_ff  <= 1'b1;
                end
            end else if (state_ff == ST_RD && scl_fall) begin
                tx_ff   <= {tx_ff[6:0], 1'b0};
                oe_n_ff <= tx_ff[7];                             // [R4]
            end
        end
    end

    // Next address: load from the two address bytes, or step and wrap.
    always_comb begin
        nxt_addr = addr_ff;
        if (en_ff && state_ff == ST_ALO && byte_done) begin
            nxt_addr = {ahi_ff[6:0], rx_ff};                     // [R8]
        end else if (mem_we ||
                     (en_ff && state_ff == ST_RD && byte_done)) begin
            nxt_addr = addr_ff + 15'h0001;                       // [R22]
        end
    end

    // The address latch survives stop and start; only reset clears it.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_ff <= '0;
        end else if (ce_i) begin
            addr_ff <= nxt_addr;
        end
    end

    // Storage array of 2**ADDR_W bytes.
    i2nv_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (8)
    ) u_array (
        .clk_sys_i (clk_sys_i),
        .ce_i      (ce_i),
        .we_i      (mem_we),                                     // [R7]
        .addr_i    (addr_ff),
        .wdata_i   (rx_ff),
        .rdata_o   (rdata)
    );

    // SDA value is always low; only the enable moves.
    assign pins_o.sda      = 1'b0;                               // [R3]
    assign pins_o.sda_oe_n = oe_n_ff;

    // Control and status words built from live engine state.
    function automatic logic [31:0] reg_read(input logic [11:0] ofs);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (ofs == `I2NV_CTRL_OFS) begin
            v[`I2NV_CTRL_EN_BIT] = en_ff;
        end else if (ofs == `I2NV_STAT_OFS) begin
            v[`I2NV_STAT_BUSY_BIT] = (state_ff != ST_IDLE);
            v[`I2NV_STAT_RD_BIT]   = (state_ff == ST_RD);
            v[`I2NV_STAT_WP_BIT]   = wp_q;
            v[`I2NV_STAT_ADDR_LSB +: ADDR_W] = addr_ff;
        end
        return v;
    endfunction

    // AHB-Lite address phase is accepted on any active transfer.
    assign ahb_take = hsel_i && hready_i && htrans_i[1];

    // Address phase capture; read data is formed here so it comes
    // from a flop in the data phase with no wait state.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_addr_ff  <= 12'h000;
            hrdata_ff   <= 32'h0000_0000;
        end else if (ce_i && hready_i) begin
            ap_valid_ff <= ahb_take;
            ap_write_ff <= hwrite_i;
            ap_addr_ff  <= haddr_i[11:0];
            if (ahb_take && !hwrite_i) begin
                hrdata_ff <= reg_read(haddr_i[11:0]);
            end
        end
    end

    // Control write in the data phase; the enable gates the engine.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_ff <= `I2NV_CTRL_RST;
        end else if (ce_i && ap_valid_ff && ap_write_ff &&
                     ap_addr_ff == `I2NV_CTRL_OFS) begin
            en_ff <= hwdata_i[`I2NV_CTRL_EN_BIT];
        end
    end

    assign hrdata_o    = hrdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i || !ce_i);

    a_drive_after_fall: assert property ( // [R4]
        $changed(oe_n_ff) |->
        $past(scl_fall || start_det || stop_det || !en_ff))
        else $error("SDA enable moved without falling SCL.");

    a_stop_to_idle: assert property ( // [R12]
        (stop_det && !start_det) |=> (state_ff == ST_IDLE && oe_n_ff))
        else $error("Stop did not return engine to idle.");

    a_start_restart: assert property ( // [R15]
        (start_det && en_ff) |=> (state_ff == ST_DEV && bit_cnt_ff == 4'h0))
        else $error("Start did not restart address reception.");

    a_wp_no_write: assert property ( // [R5]
        mem_we |-> !wp_q)
        else $error("Array written while protected.");

    a_wp_hold_addr: assert property ( // [R23]
        (en_ff && state_ff == ST_WR && byte_done && wp_q && !start_det &&
         !stop_det) |=> (addr_ff == $past(addr_ff) && oe_n_ff))
        else $error("Protected write acked or moved the address.");

    a_write_acked: assert property ( // [R9]
        (en_ff && state_ff == ST_WR && byte_done && !wp_q && !start_det &&
         !stop_det) |-> mem_we ##1 (!oe_n_ff && addr_ff ==
         ADDR_W'($past(addr_ff) + 15'h0001)))
        else $error("Unprotected write not done before its ack.");

    a_addr_load: assert property ( // [R8]
        (en_ff && state_ff == ST_ALO && byte_done && !start_det &&
         !stop_det) |=> addr_ff == {$past(ahi_ff[6:0]), $past(rx_ff)})
        else $error("Address latch not loaded from 15 address bits.");

    a_select_nack: assert property ( // [R1]
        (en_ff && state_ff == ST_DEV && byte_done && !dev_match &&
         !start_det && !stop_det) |=> (state_ff == ST_IDLE && oe_n_ff))
        else $error("Unselected device answered.");

    a_read_release: assert property ( // [R20]
        (state_ff == ST_RD && byte_done && !start_det && !stop_det)
        |=> oe_n_ff [*1])
        else $error("Read byte did not release SDA for the ack.");

endmodule // i2nv_top

/* File: i2nv_mst.sv */
`timescale 1ns/10ps

// Two-wire bus master: owns SCL, pulls SDA low or lets the pull-up win.
module i2nv_mst (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_n_o
);
    int hp = 4; // Half SCL period in clocks: 160 ns per SCL period.

    // The bus idles released with the clock high.
    initial begin
        scl_o      = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // One pulse: data set only while SCL is low, line sampled late high.
    task automatic clk_bit(input logic b, output logic s);
        @(posedge clk_sys_i);
        sda_oe_n_o <= b;
        repeat (hp - 1) @(posedge clk_sys_i);
        scl_o <= 1'b1;
        repeat (hp) @(posedge clk_sys_i);
        s = sda_i;
        scl_o <= 1'b0;
    endtask

    // Start, also repeated: release SDA, raise SCL, then pull SDA low.
    task automatic start();
        @(posedge clk_sys_i);
        sda_oe_n_o <= 1'b1;
        repeat (hp) @(posedge clk_sys_i);
        scl_o <= 1'b1;
        repeat (hp) @(posedge clk_sys_i);
        sda_oe_n_o <= 1'b0;
        repeat (hp) @(posedge clk_sys_i);
        scl_o <= 1'b0;
    endtask

    // Stop is only issued with SDA in our hands, never inside a read byte.
    task automatic stop();
        @(posedge clk_sys_i);
        sda_oe_n_o <= 1'b0;
        repeat (hp) @(posedge clk_sys_i);
        scl_o <= 1'b1;
        repeat (hp) @(posedge clk_sys_i);
        sda_oe_n_o <= 1'b1;
        repeat (hp) @(posedge clk_sys_i);
    endtask

    // Byte out MSB first, then release SDA and read the acknowledge.
    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, ack_n);
    endtask

    // Byte in MSB first, then our own acknowledge or no-acknowledge.
    task automatic rd_byte(input logic ack_n, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(ack_n, s);
    endtask
endmodule // i2nv_mst

/* File: tb_i2c_slave_nvram_front_end.sv */
`timescale 1ns/10ps
`define I2NV_CHK(nm, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected %s: expected %h seen %h", nm, exp, got); \
        end \
    end

module tb_i2c_slave_nvram_front_end;
    import i2nv_pkg::*;
    localparam logic [3:0] DEVT = 4'h6; // Arbitrary device-type code.
    logic          clk_sys_i;
    logic          resetn_i;
    logic [2:0]    straps;
    logic          wp;
    logic          hsel;
    logic [31:0]   haddr;
    logic [31:0]   hwdata;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [2:0]    hsize;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          scl;
    logic          m_oe_n;
    logic          k;
    logic [7:0]    d;
    logic [31:0]   v;
    i2nv_pin_in_s  pins_in;
    i2nv_pin_out_s pins_out;
    int            err_count = 0;
    int            cmp_count = 0;

    // Wired-AND SDA with the pull-up; released parties read high.
    assign pins_in.scl = scl;
    assign pins_in.sda = m_oe_n & (pins_out.sda_oe_n | pins_out.sda);

    i2nv_top #(.ADDR_W(15), .DEV_TYPE(DEVT)) u_i2nv_top (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .pins_i(pins_in), .pins_o(pins_out),
        .device_select_straps_i(straps), .wp_i(wp),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp));

    i2nv_mst u_i2nv_mst (.clk_sys_i(clk_sys_i), .sda_i(pins_in.sda),
        .scl_o(scl), .sda_oe_n_o(m_oe_n));

    // 50 MHz system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // One single-word transfer; every wait ends on the slave's ready.
    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_i);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Select for write and load a two-byte memory address.
    task automatic addr_set(input logic [15:0] a);
        u_i2nv_mst.start();
        u_i2nv_mst.wr_byte({DEVT, straps, 1'b0}, k);
        `I2NV_CHK("select ack", 1'b0, k);
        u_i2nv_mst.wr_byte(a[15:8], k);
        `I2NV_CHK("addr hi ack", 1'b0, k);
        u_i2nv_mst.wr_byte(a[7:0], k);
        `I2NV_CHK("addr lo ack", 1'b0, k);
    endtask

    task automatic wr_data(input logic [7:0] b, input logic exp_n);
        u_i2nv_mst.wr_byte(b, k);
        `I2NV_CHK("data ack", exp_n, k);
    endtask

    // Current-address read of n bytes, no-acknowledge on the last.
    task automatic rd_cur(input logic [7:0] e0, input logic [7:0] e1,
                          input int n);
        u_i2nv_mst.start();
        u_i2nv_mst.wr_byte({DEVT, straps, 1'b1}, k);
        `I2NV_CHK("read select ack", 1'b0, k);
        u_i2nv_mst.rd_byte(n == 1, d);
        `I2NV_CHK("read byte 0", e0, d);
        if (n == 2) begin
            u_i2nv_mst.rd_byte(1'b1, d);
            `I2NV_CHK("read byte 1", e1, d);
        end
        u_i2nv_mst.stop();
    endtask

    task automatic st_addr(input logic [14:0] e);
        ahb(32'h4, 1'b0, 32'h0, v);
        `I2NV_CHK("address latch", e, v[30:16]);
    endtask

    // Register resets, read-only status, unmapped place, released SDA.
    task automatic t_regs();
        ahb(32'h0, 1'b0, 32'h0, v);
        `I2NV_CHK("ctrl reset", 32'h1, v);
        ahb(32'h4, 1'b1, 32'hffffffff, v);
        ahb(32'h10, 1'b1, 32'hffffffff, v);
        ahb(32'h4, 1'b0, 32'h0, v);
        `I2NV_CHK("status", 32'h0, v);
        ahb(32'h10, 1'b0, 32'h0, v);
        `I2NV_CHK("unmapped", 32'h0, v);
        `I2NV_CHK("hresp", 1'b0, hresp);
        `I2NV_CHK("sda value", 1'b0, pins_out.sda);
        `I2NV_CHK("sda idle", 1'b1, pins_out.sda_oe_n);
    endtask

    // Write with the ignored top bit set, then read back at once.
    task automatic t_write_read();
        addr_set(16'hff12);
        wr_data(8'ha5, 1'b0);
        wr_data(8'h3c, 1'b0);
        u_i2nv_mst.stop();
        st_addr(15'h7f14);
        addr_set(16'h7f12);
        rd_cur(8'ha5, 8'h3c, 2);
        st_addr(15'h7f14);
    endtask

    // Write and read across the top of the array.
    task automatic t_wrap();
        addr_set(16'h7fff);
        wr_data(8'h11, 1'b0);
        wr_data(8'h22, 1'b0);
        u_i2nv_mst.stop();
        st_addr(15'h0001);
        addr_set(16'h7fff);
        rd_cur(8'h11, 8'h22, 2);
    endtask

    // Protected writes are refused and leave data and latch alone.
    task automatic t_protect();
        addr_set(16'h0100);
        wr_data(8'h55, 1'b0);
        wr_data(8'h66, 1'b0);
        u_i2nv_mst.stop();
        wp <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        ahb(32'h4, 1'b0, 32'h0, v);
        `I2NV_CHK("wp status", 1'b1, v[2]);
        addr_set(16'h0100);
        wr_data(8'h77, 1'b1);
        wr_data(8'h78, 1'b1);
        u_i2nv_mst.stop();
        st_addr(15'h0100);
        wp <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        addr_set(16'h0100);
        rd_cur(8'h55, 8'h66, 2);
    endtask

    // Every strap value matches its own select bits and not those with bit 2 flipped.
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            straps <= 3'(s);
            repeat (4) @(posedge clk_sys_i);
            u_i2nv_mst.start();
            u_i2nv_mst.wr_byte({DEVT, 3'(s), 1'b0}, k);
            `I2NV_CHK("strap match", 1'b0, k);
            u_i2nv_mst.stop();
            u_i2nv_mst.start();
            u_i2nv_mst.wr_byte({DEVT, 3'(s) ^ 3'h4, 1'b0}, k);
            `I2NV_CHK("strap mismatch", 1'b1, k);
            u_i2nv_mst.stop();
        end
        u_i2nv_mst.start();
        u_i2nv_mst.wr_byte({~DEVT, straps, 1'b0}, k);
        `I2NV_CHK("type mismatch", 1'b1, k);
        u_i2nv_mst.stop();
        straps <= 3'h0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    // Start or stop in mid-byte drops the byte and the operation.
    task automatic t_abort();
        addr_set(16'h0200);
        wr_data(8'h01, 1'b0);
        u_i2nv_mst.stop();
        addr_set(16'h0200);
        for (int i = 0; i < 4; i++) begin
            u_i2nv_mst.clk_bit(1'b1, k);
        end
        ahb(32'h4, 1'b0, 32'h0, v);
        `I2NV_CHK("busy mid byte", 1'b1, v[0]);
        rd_cur(8'h01, 8'h00, 1);
        addr_set(16'h0200);
        for (int i = 0; i < 3; i++) begin
            u_i2nv_mst.clk_bit(1'b0, k);
        end
        u_i2nv_mst.stop();
        ahb(32'h4, 1'b0, 32'h0, v);
        `I2NV_CHK("busy after stop", 1'b0, v[0]);
        st_addr(15'h0200);
        rd_cur(8'h01, 8'h00, 1);
    endtask

    // A disabled engine answers nothing until enabled again.
    task automatic t_enable();
        ahb(32'h0, 1'b1, 32'h0, v);
        u_i2nv_mst.start();
        u_i2nv_mst.wr_byte({DEVT, straps, 1'b0}, k);
        `I2NV_CHK("disabled select", 1'b1, k);
        u_i2nv_mst.stop();
        ahb(32'h0, 1'b1, 32'h1, v);
        ahb(32'h0, 1'b0, 32'h0, v);
        `I2NV_CHK("ctrl enable", 32'h1, v);
        addr_set(16'h0200);
        rd_cur(8'h01, 8'h00, 1);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence; the bus is left idle high across reset release.
    initial begin
        resetn_i = 1'b0;
        straps = 3'h0;
        wp = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        t_regs();
        t_write_read();
        t_wrap();
        t_protect();
        t_select();
        t_abort();
        t_enable();
        print_verdict();
    end

    // The tests need about 6400 cycles; this cuts a hang well beyond.
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_count++;
        print_verdict();
    end
endmodule // tb_i2c_slave_nvram_front_end
